// *** pkg/fss_pkg.sv ***
`default_nettype none
package fss_pkg;

  // ----------------------------------------
  // Bus geometry
  // ----------------------------------------
  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;

  // ----------------------------------------
  // Register indices, byte address is index times four
  // ----------------------------------------
  localparam logic [7:0] IDX_MAIN_STATUS = 8'h00;
  localparam logic [7:0] IDX_PRESENCE = 8'h06;
  localparam logic [7:0] IDX_FAN_ONE = 8'h10;
  localparam logic [7:0] IDX_FAN_TWO = 8'h11;
  localparam logic [7:0] IDX_OFS_LOCAL = 8'h30;
  localparam logic [7:0] IDX_OFS_REMOTE_ONE = 8'h31;
  localparam logic [7:0] IDX_OFS_REMOTE_TWO = 8'h32;
  localparam logic [7:0] IDX_INT_STATUS = 8'h60;
  localparam logic [7:0] IDX_INT_MASK = 8'h61;

  // ----------------------------------------
  // Fan status fields
  // ----------------------------------------
  localparam int FS_MISSING = 0;
  localparam int FS_REMOVED = 1;
  localparam int FS_FAULT = 2;
  localparam int FS_FAULT_L = 3;
  localparam int FS_SLEEP = 4;
  localparam int FS_PRIO = 5;
  localparam int FS_TACH_L = 6;
  localparam int FS_INSERTED = 7;

  // ----------------------------------------
  // Other fields and reset values
  // ----------------------------------------
  localparam int PR_LOCAL = 0;
  localparam int PR_REMOTE_ONE = 1;
  localparam int PR_REMOTE_TWO = 2;
  localparam int MS_FAN_SUMMARY = 6;
  localparam int EV_PER_FAN = 4;
  localparam logic [7:0] OFS_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] INT_RST = 8'h00;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    FSS_SPD_NORMAL,
    FSS_SPD_ALARM,
    FSS_SPD_HOTPLUG,
    FSS_SPD_STOP
  } fss_speed_e;

  typedef struct packed {
    logic missing;
    logic faultN;
    logic tachFault;
    logic alarmReq;
    logic hotPlugReq;
    logic sleepAlarmEn;
    logic overTemp;
  } fss_fan_in_s;

  typedef struct packed {
    logic [7:0] status;
    logic [EV_PER_FAN-1:0] events;
    fss_speed_e speed;
  } fss_fan_out_s;

endpackage
`default_nettype wire

// *** rtl/fss_fan_channel.sv ***
`default_nettype none
module fss_fan_channel
  import fss_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire fss_fan_in_s pins,
  input wire logic wrEn,
  input wire logic [7:0] wrData,
  output fss_fan_out_s out
);

  logic armed;
  logic prevMissing;
  logic prevFaultN;
  logic removedL;
  logic faultL;
  logic tachL;
  logic insertedL;
  logic sleep;
  logic prio;
  logic removeEv;
  logic insertEv;
  logic faultEv;
  logic tachEv;
  fss_speed_e speed;
  fss_speed_e next_speed;

  // ----------------------------------------
  // Pin history and edges
  // ----------------------------------------
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      armed <= 1'b0;
      prevMissing <= 1'b0;
      prevFaultN <= 1'b1;
    end else begin
      armed <= 1'b1;
      prevMissing <= pins.missing;
      prevFaultN <= pins.faultN;
    end
  end

  assign removeEv = armed & pins.missing & ~prevMissing;
  assign insertEv = armed & ~pins.missing & prevMissing;
  assign faultEv = armed & ~sleep & ~pins.missing & prevFaultN & ~pins.faultN;
  assign tachEv = ~sleep & ~pins.missing & pins.tachFault;

  // ----------------------------------------
  // Latched event bits, set beats clear
  // ----------------------------------------
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      removedL <= 1'b0;
      faultL <= 1'b0;
      tachL <= 1'b0;
      insertedL <= 1'b0;
    end else begin
      removedL <= removeEv | (removedL & ~(wrEn & ~wrData[FS_REMOVED]));
      insertedL <= insertEv | (insertedL & ~(wrEn & ~wrData[FS_INSERTED]));
      if (pins.missing) begin
        faultL <= 1'b0;
        tachL <= 1'b0;
      end else begin
        faultL <= faultEv | (faultL & ~(wrEn & ~wrData[FS_FAULT_L]));
        tachL <= tachEv | (tachL & ~(wrEn & ~wrData[FS_TACH_L]));
      end
    end
  end

  // ----------------------------------------
  // Sleep and priority controls
  // ----------------------------------------
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sleep <= 1'b0;
      prio <= 1'b0;
    end else if (wrEn) begin
      sleep <= wrData[FS_SLEEP];
      prio <= wrData[FS_PRIO];
    end
  end

  // ----------------------------------------
  // Speed selection
  // ----------------------------------------
  always_comb begin
    if (sleep) begin
      next_speed = (pins.sleepAlarmEn & pins.overTemp) ? FSS_SPD_ALARM : FSS_SPD_STOP;
    end else if (pins.alarmReq & pins.hotPlugReq & ~insertedL) begin
      next_speed = prio ? FSS_SPD_HOTPLUG : FSS_SPD_ALARM;
    end else if (pins.alarmReq) begin
      next_speed = FSS_SPD_ALARM;
    end else if (pins.hotPlugReq & ~insertedL) begin
      next_speed = FSS_SPD_HOTPLUG;
    end else begin
      next_speed = FSS_SPD_NORMAL;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      speed <= FSS_SPD_NORMAL;
    end else begin
      speed <= next_speed;
    end
  end

  // ----------------------------------------
  // Status view
  // ----------------------------------------
  always_comb begin
    out.status = {insertedL, tachL, prio, sleep, faultL, ~pins.faultN, removedL, pins.missing};
    out.events = {insertEv, tachEv, faultEv, removeEv};
    out.speed = speed;
  end

endmodule
`default_nettype wire

// *** rtl/fss_regbank.sv ***
// Function
// - Presence bit 0 always reads one
// - Presence bits 1,2 show detected remote diodes
// - Presence bits 3 to 7 read zero
// - Status bit 0 follows fan missing pin
// - Bit 1 latches fan removal until cleared
// - Bit 2 is inverse of fault pin
// - Bit 3 latches fault edge until cleared
// - Missing fan holds bits 3,6 cleared
// - Sleep stops fan, suspends fault monitoring
// - Sleeping fan alarms on overtemperature only with sleepAlarmEn set
// - Bit 5 picks hot-plug or alarm speed
// - Bit 6 latches tach fault until cleared
// - Bit 7 latches fan insertion until cleared
// - Hot-plugged fan runs at normal speed
// - Fan status registers at 10h, 11h
// - Per-channel offset added to temperature
// - Offsets at 30h, 31h, 32h
// - Summary flag ORs fan event bits
//
// Decided for this implementation: the APB register port.
`default_nettype none
module fss_regbank
  import fss_pkg::*;
#(
  parameter int FANS = 2,
  parameter int TEMP_CH = 3
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic remoteDiodeOnePresent,
  input wire logic remoteDiodeTwoPresent,
  input wire fss_fan_in_s [FANS-1:0] fanPins,
  input wire logic [TEMP_CH-1:0][REG_W-1:0] measuredTemp,
  output logic [TEMP_CH-1:0][REG_W-1:0] correctedTemp,
  output fss_speed_e [FANS-1:0] fanSpeed,
  output logic irq
);

  if (FANS != 2 || TEMP_CH != 3) begin : gBadParam
    $error("fss_regbank: register map serves two fans, three channels");
  end

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic access;
  logic aligned;
  logic wrStrobe;
  logic [7:0] index;
  logic [7:0] wrByte;
  logic mapped;
  logic [7:0] readByte;
  logic armed;
  logic remoteOne;
  logic remoteTwo;
  logic [7:0] presence;
  logic [7:0] mainStatus;
  logic fanSummary;
  logic [FANS-1:0] fanWr;
  fss_fan_out_s [FANS-1:0] fanOut;
  logic [TEMP_CH-1:0][REG_W-1:0] offset;
  logic [TEMP_CH-1:0] offsetWr;
  logic [7:0] intStatus;
  logic [7:0] intMask;
  logic [7:0] intEvents;
  logic [7:0] intClear;

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  assign access = psel & penable;
  assign aligned = (paddr[1:0] == 2'b00);
  assign index = paddr[9:2];
  assign wrByte = pwdata[7:0];
  assign wrStrobe = access & pwrite & aligned & mapped;
  assign pready = 1'b1;
  assign pslverr = access & ~(aligned & mapped);

  always_comb begin
    case (index)
      IDX_MAIN_STATUS: mapped = 1'b1;
      IDX_PRESENCE: mapped = 1'b1;
      IDX_FAN_ONE: mapped = 1'b1;
      IDX_FAN_TWO: mapped = 1'b1;
      IDX_OFS_LOCAL: mapped = 1'b1;
      IDX_OFS_REMOTE_ONE: mapped = 1'b1;
      IDX_OFS_REMOTE_TWO: mapped = 1'b1;
      IDX_INT_STATUS: mapped = 1'b1;
      IDX_INT_MASK: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // ----------------------------------------
  // Read multiplexer
  // ----------------------------------------
  always_comb begin
    case (index)
      IDX_MAIN_STATUS: readByte = mainStatus;
      IDX_PRESENCE: readByte = presence;
      IDX_FAN_ONE: readByte = fanOut[0].status;
      IDX_FAN_TWO: readByte = fanOut[1].status;
      IDX_OFS_LOCAL: readByte = offset[0];
      IDX_OFS_REMOTE_ONE: readByte = offset[1];
      IDX_OFS_REMOTE_TWO: readByte = offset[2];
      IDX_INT_STATUS: readByte = intStatus;
      IDX_INT_MASK: readByte = intMask;
      default: readByte = 8'h00;
    endcase
  end

  always_comb begin
    prdata = '0;
    if (access & ~pwrite & aligned & mapped) begin
      prdata[7:0] = readByte;
    end
  end

  // ----------------------------------------
  // Sensor presence, captured once after reset
  // ----------------------------------------
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      armed <= 1'b0;
    end else begin
      armed <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      remoteOne <= 1'b0;
      remoteTwo <= 1'b0;
    end else if (!armed) begin
      remoteOne <= remoteDiodeOnePresent;
      remoteTwo <= remoteDiodeTwoPresent;
    end
  end

  always_comb begin
    presence = 8'h00;
    presence[PR_LOCAL] = 1'b1;
    presence[PR_REMOTE_ONE] = remoteOne;
    presence[PR_REMOTE_TWO] = remoteTwo;
  end

  // ----------------------------------------
  // Main status summary
  // ----------------------------------------
  always_comb begin
    fanSummary = 1'b0;
    for (int f = 0; f < FANS; f++) begin
      fanSummary = fanSummary | fanOut[f].status[FS_REMOVED]
        | fanOut[f].status[FS_FAULT_L] | fanOut[f].status[FS_TACH_L]
        | fanOut[f].status[FS_INSERTED];
    end
    mainStatus = 8'h00;
    mainStatus[MS_FAN_SUMMARY] = fanSummary;
  end

  // ----------------------------------------
  // Fan channels
  // ----------------------------------------
  for (genvar f = 0; f < FANS; f++) begin : gFan
    assign fanWr[f] = wrStrobe & (index == IDX_FAN_ONE + 8'(f));
    assign fanSpeed[f] = fanOut[f].speed;
    assign intEvents[f*EV_PER_FAN +: EV_PER_FAN] = fanOut[f].events;

    fss_fan_channel uFan (
      .clock(clock),
      .arst_n(arst_n),
      .pins(fanPins[f]),
      .wrEn(fanWr[f]),
      .wrData(wrByte),
      .out(fanOut[f])
    );
  end

  // ----------------------------------------
  // Temperature offsets
  // ----------------------------------------
  for (genvar c = 0; c < TEMP_CH; c++) begin : gOfs
    assign offsetWr[c] = wrStrobe & (index == IDX_OFS_LOCAL + 8'(c));

    always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
        offset[c] <= OFS_RST;
      end else if (offsetWr[c]) begin
        offset[c] <= wrByte;
      end
    end
  end

  fss_temp_offset #(
    .CHANNELS(TEMP_CH),
    .WIDTH(REG_W)
  ) uOffset (
    .clock(clock),
    .arst_n(arst_n),
    .measured(measuredTemp),
    .offset(offset),
    .corrected(correctedTemp)
  );

  // ----------------------------------------
  // Interrupt status, mask and output
  // ----------------------------------------
  assign intClear = (wrStrobe && index == IDX_INT_STATUS) ? wrByte : 8'h00;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      intStatus <= INT_RST;
    end else begin
      intStatus <= (intStatus & ~intClear) | intEvents;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      intMask <= MASK_RST;
    end else if (wrStrobe && index == IDX_INT_MASK) begin
      intMask <= wrByte;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(intStatus & intMask);
    end
  end

endmodule
`default_nettype wire

// *** rtl/fss_temp_offset.sv ***
`default_nettype none
module fss_temp_offset
  import fss_pkg::*;
#(
  parameter int CHANNELS = 3,
  parameter int WIDTH = 8
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [CHANNELS-1:0][WIDTH-1:0] measured,
  input wire logic [CHANNELS-1:0][WIDTH-1:0] offset,
  output logic [CHANNELS-1:0][WIDTH-1:0] corrected
);

  if (CHANNELS < 1 || WIDTH < 2) begin : gBadParam
    $error("fss_temp_offset: unsupported parameters");
  end

  // ----------------------------------------
  // Per-channel correction adder
  // ----------------------------------------
  for (genvar c = 0; c < CHANNELS; c++) begin : gChan
    always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
        corrected[c] <= '0;
      end else begin
        corrected[c] <= WIDTH'(measured[c] + offset[c]);
      end
    end
  end

endmodule
`default_nettype wire

// *** sim/fan_status_sensor_presence_tb.sv ***
`default_nettype none
module fan_status_sensor_presence_tb
  import fss_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // Signals
  // ----
  logic clock = 0;
  logic arst_n = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0;
  logic [DATA_W-1:0] prdata;
  logic pready, pslverr, irq, d1, d2;
  fss_fan_in_s [1:0] fanPins;
  logic [2:0][7:0] measuredTemp = '0;
  logic [2:0][7:0] correctedTemp;
  logic [2:0][7:0] ofs;
  fss_speed_e [1:0] fanSpeed;
  logic [1:0] seated = 2'h3;
  logic [1:0] faultOn = 2'h0;
  logic [1:0] tachOn = 2'h0;
  logic [1:0][3:0] ctl = '0;
  logic [8:0] expQ[$];
  int mismatches = 0;
  int check_count = 0;
  int seed = 32'h33BE263B;

  fss_regbank u_dut (
    .clock(clock), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .remoteDiodeOnePresent(d1), .remoteDiodeTwoPresent(d2), .fanPins(fanPins),
    .measuredTemp(measuredTemp), .correctedTemp(correctedTemp), .fanSpeed(fanSpeed), .irq(irq)
  );
  fss_fan_model u_fans (
    .seated(seated), .faultOn(faultOn), .tachOn(tachOn), .ctl(ctl),
    .diodeOne(d1), .diodeTwo(d2), .pins(fanPins)
  );
  // ----
  // Tasks
  // ----
  task automatic chk(input string n, input logic [32:0] e, input logic [32:0] s);
    check_count++;
    if (e !== s) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d,
      input logic [1:0] lo = 2'h0);
    @(posedge clock);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= {idx, lo};
    pwdata <= {24'h0, d};
    @(posedge clock);
    penable <= 1;
    do @(posedge clock); while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rd(input logic [7:0] idx, input logic [8:0] e, input logic [1:0] lo = 2'h0);
    expQ.push_back(e);
    xfer(0, idx, 8'h00, lo);
  endtask
  task automatic settle();
    repeat (3) @(posedge clock);
  endtask
  task automatic speed(input fss_speed_e e, input int f);
    @(negedge clock);
    chk("fan speed", {31'h0, e}, {31'h0, fanSpeed[f]});
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ----
  // Clock, watchdog, read monitor
  // ----
  initial begin
    forever #10 clock = ~clock;
  end
  initial begin
    #400000;
    mismatches++;
    report_and_stop();
  end
  always @(posedge clock) begin
    if (psel && penable && pready === 1'b1 && !pwrite && expQ.size() > 0) begin
      chk("read data", {expQ[0][8], 24'h0, expQ[0][7:0]}, {pslverr, prdata});
      void'(expQ.pop_front());
    end
  end
  // ----
  // Scenarios
  // ----
  initial begin
    repeat (12) @(posedge clock);
    arst_n <= 1;
    repeat (2) @(posedge clock);
    rd(IDX_PRESENCE, 9'h003);
    xfer(1, IDX_PRESENCE, 8'hFF);
    rd(IDX_PRESENCE, 9'h003);
    rd(IDX_FAN_ONE, 9'h000);
    rd(IDX_FAN_TWO, 9'h000);
    rd(8'h07, 9'h100);
    rd(IDX_FAN_ONE, 9'h100, 2'h2);
    for (int c = 0; c < 3; c++) begin
      ofs[c] = 8'($random(seed));
      rd(IDX_OFS_LOCAL + 8'(c), 9'h000);
      xfer(1, IDX_OFS_LOCAL + 8'(c), ofs[c]);
      measuredTemp[c] <= 8'($random(seed));
      rd(IDX_OFS_LOCAL + 8'(c), {1'b0, ofs[c]});
    end
    settle();
    @(negedge clock);
    for (int c = 0; c < 3; c++) begin
      chk("corrected", 33'(8'(measuredTemp[c] + ofs[c])), 33'(correctedTemp[c]));
    end
    xfer(1, IDX_INT_MASK, 8'h01);
    seated[0] <= 0;
    settle();
    rd(IDX_FAN_ONE, 9'h003);
    rd(IDX_MAIN_STATUS, 9'h040);
    rd(IDX_INT_STATUS, 9'h001);
    @(negedge clock);
    chk("irq", 33'h1, {32'h0, irq});
    xfer(1, IDX_INT_STATUS, 8'h01);
    settle();
    @(negedge clock);
    chk("irq", 33'h0, {32'h0, irq});
    xfer(1, IDX_FAN_ONE, 8'hCA);
    rd(IDX_FAN_ONE, 9'h003);
    xfer(1, IDX_FAN_ONE, 8'h00);
    faultOn[0] <= 1;
    tachOn[0] <= 1;
    settle();
    rd(IDX_FAN_ONE, 9'h005);
    faultOn[0] <= 0;
    tachOn[0] <= 0;
    seated[0] <= 1;
    settle();
    rd(IDX_FAN_ONE, 9'h080);
    rd(IDX_MAIN_STATUS, 9'h040);
    xfer(1, IDX_FAN_ONE, 8'h00);
    faultOn[0] <= 1;
    settle();
    rd(IDX_FAN_ONE, 9'h00C);
    faultOn[0] <= 0;
    tachOn[0] <= 1;
    settle();
    rd(IDX_FAN_ONE, 9'h048);
    tachOn[0] <= 0;
    xfer(1, IDX_FAN_ONE, 8'h00);
    rd(IDX_FAN_ONE, 9'h000);
    xfer(1, IDX_FAN_ONE, 8'h10);
    faultOn[0] <= 1;
    tachOn[0] <= 1;
    settle();
    rd(IDX_FAN_ONE, 9'h014);
    speed(FSS_SPD_STOP, 0);
    ctl[0] <= 4'h3;
    settle();
    speed(FSS_SPD_ALARM, 0);
    ctl[0] <= 4'h0;
    faultOn[0] <= 0;
    tachOn[0] <= 0;
    ctl[1] <= 4'hC;
    xfer(1, IDX_FAN_TWO, 8'h20);
    settle();
    speed(FSS_SPD_HOTPLUG, 1);
    xfer(1, IDX_FAN_TWO, 8'h00);
    settle();
    speed(FSS_SPD_ALARM, 1);
    ctl[1] <= 4'h4;
    seated[1] <= 0;
    settle();
    seated[1] <= 1;
    settle();
    rd(IDX_FAN_TWO, 9'h082);
    speed(FSS_SPD_NORMAL, 1);
    report_and_stop();
  end
endmodule
`default_nettype wire

// *** sim/fss_checker.sv ***
`default_nettype none
module fss_checker
  import fss_pkg::*;
#(
  parameter int FANS = 2,
  parameter int TEMP_CH = 3
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [DATA_W-1:0] prdata,
  input wire fss_fan_in_s [FANS-1:0] fanPins,
  input wire logic [TEMP_CH-1:0][REG_W-1:0] measuredTemp,
  input wire logic [TEMP_CH-1:0][REG_W-1:0] correctedTemp
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  // ----
  // Read decode and sequences
  // ----
  wire logic rdAcc = psel && penable && !pwrite;
  wire logic rdOne = rdAcc && paddr == {IDX_FAN_ONE, 2'b00};
  wire logic rdTwo = rdAcc && paddr == {IDX_FAN_TWO, 2'b00};
  sequence plugRead(p, r);
    $fell(p) ##[1:8] r;
  endsequence
  sequence pullRead(p, r);
    $rose(p) ##[1:8] r;
  endsequence
  // ----
  // Assertions
  // ----
  AST_PRESENCE: assert property (
    rdAcc && paddr == {IDX_PRESENCE, 2'b00} |-> prdata[0] && prdata[7:3] == 5'h00)
    else $error("presence bits wrong");
  AST_MISSING_LIVE: assert property (
    rdOne && $stable(fanPins[0].missing) && $past(fanPins[0].missing, 2) == fanPins[0].missing
    |-> prdata[0] == fanPins[0].missing) else $error("missing bit not live");
  AST_FAULT_LIVE: assert property (
    rdOne && $stable(fanPins[0].faultN) && $past(fanPins[0].faultN, 2) == fanPins[0].faultN
    |-> prdata[2] == !fanPins[0].faultN) else $error("fault bit not inverse of pin");
  AST_REMOVE: assert property (
    pullRead(fanPins[0].missing, rdOne) |-> prdata[1]) else $error("removal not latched");
  AST_INSERT_ONE: assert property (
    plugRead(fanPins[0].missing, rdOne) |-> prdata[7]) else $error("insert not latched");
  AST_INSERT_TWO: assert property (
    plugRead(fanPins[1].missing, rdTwo) |-> prdata[7]) else $error("insert two not latched");
  AST_FORCED_CLEAR: assert property (
    rdOne && fanPins[0].missing && $past(fanPins[0].missing)
    |-> prdata[3] == 1'b0 && prdata[6] == 1'b0) else $error("fault latch while missing");
  for (genvar c = 0; c < TEMP_CH; c++) begin : g_ofs
    AST_OFFSET: assert property (
      psel && penable && pwrite && paddr == {IDX_OFS_LOCAL + 8'(c), 2'b00} |-> ##2
      correctedTemp[c] == 8'($past(measuredTemp[c]) + $past(pwdata[7:0], 2)))
      else $error("corrected temperature wrong");
  end
endmodule

bind fss_regbank fss_checker #(.FANS(FANS), .TEMP_CH(TEMP_CH)) u_chk (
  .clock(clock), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .fanPins(fanPins),
  .measuredTemp(measuredTemp), .correctedTemp(correctedTemp)
);
`default_nettype wire

// *** sim/fss_fan_model.sv ***
`default_nettype none
module fss_fan_model
  import fss_pkg::*;
#(
  parameter logic DIODE_ONE = 1'b1,
  parameter logic DIODE_TWO = 1'b0
) (
  input wire logic [1:0] seated,
  input wire logic [1:0] faultOn,
  input wire logic [1:0] tachOn,
  input wire logic [1:0][3:0] ctl,
  output logic diodeOne,
  output logic diodeTwo,
  output fss_fan_in_s [1:0] pins
);
  // ----
  // Fan pins and diode straps
  // ----
  assign diodeOne = DIODE_ONE;
  assign diodeTwo = DIODE_TWO;
  always_comb begin
    for (int f = 0; f < 2; f++) begin
      pins[f].missing = !seated[f];
      pins[f].faultN = !faultOn[f];
      pins[f].tachFault = tachOn[f];
      {pins[f].alarmReq, pins[f].hotPlugReq, pins[f].sleepAlarmEn, pins[f].overTemp} = ctl[f];
    end
  end
endmodule
`default_nettype wire
